// *** hw/pxc_map.vh ***
// Purpose: Register map, field positions and timing for the proximity setup block
// Assumes: 200 MHz core clock
// Notes:   Values only, no logic
`ifndef PXC_MAP_VH
`define PXC_MAP_VH

`define PXC_ADDR_SETUP      8'h0b
`define PXC_ADDR_CONFIG     8'h0f
`define PXC_RST_SETUP       8'h0b
`define PXC_RST_CONFIG      8'h19

// Setup fields
`define PXC_SU_RANGE_HI     7
`define PXC_SU_RANGE_LO     6
`define PXC_SU_RSVD         5
`define PXC_SU_HYST_DIS     4
`define PXC_SU_SETTLE_MSB   3
`define PXC_SU_SETTLE_LSB   0

// Config fields
`define PXC_CF_CONST_THR    7
`define PXC_CF_CMP_MSB      6
`define PXC_CF_CMP_LSB      5
`define PXC_CF_CONV_EN      4
`define PXC_CF_RSVD         3
`define PXC_CF_OP_MSB       2
`define PXC_CF_OP_LSB       0

// Converter and comparator mode codes
`define PXC_OP_IDLE         3'h0
`define PXC_OP_CONT         3'h1
`define PXC_OP_SINGLE       3'h2
`define PXC_CMP_NEG         2'h0
`define PXC_CMP_POS         2'h1
`define PXC_CMP_IN_WIN      2'h2
`define PXC_CMP_OUT_WIN     2'h3

// Serial slave address, arbitrary
`define PXC_DEV_ADDR        7'h48

// Conversion time in ns and clock period in ns
`define PXC_CONV_TIME_NS    5000
`define PXC_CLK_PERIOD_NS   5
`define PXC_CONV_CYCLES     (`PXC_CONV_TIME_NS / `PXC_CLK_PERIOD_NS)

`endif

// *** hw/pxc_cmp.v ***
// Purpose: Detection comparator for fixed and adaptive threshold modes
// Assumes: Data, average and threshold are 12-bit unsigned codes
// Notes:   Combinational; caller registers the result
`timescale 1ns/100ps
`include "pxc_map.vh"
module pxc_cmp
(
  input  wire [11:0] data_i,
  input  wire [11:0] avg_i,
  input  wire [7:0]  sens_i,
  input  wire [11:0] thr_i,
  input  wire        const_thr_i,
  input  wire [1:0]  cmp_mode_i,
  input  wire        hyst_dis_i,
  input  wire        prev_i,
  output reg         active_o
);
  reg signed [14:0] d;
  reg signed [14:0] lo;
  reg signed [14:0] hi;
  reg signed [14:0] h;

  always @*
  begin
    d  = {3'h0, data_i};
    lo = {3'h0, avg_i} - {7'h00, sens_i};
    hi = {3'h0, avg_i} + {7'h00, sens_i};
    // Hysteresis: quarter of the sensitivity (sens_i / 4), only while already active
    h  = (prev_i && !hyst_dis_i) ? {9'h000, sens_i[7:2]} : 15'sh0000; // [RULE5]
    active_o = 1'b0;
    if (const_thr_i)
    begin
      // Fixed threshold: no hysteresis, window modes inactive
      case (cmp_mode_i) // [RULE6] [RULE10] [RULE13]
        `PXC_CMP_NEG: active_o = data_i < thr_i;
        `PXC_CMP_POS: active_o = data_i > thr_i;
        default:      active_o = 1'b0;
      endcase
    end
    else
    begin
      case (cmp_mode_i) // [RULE11] [RULE12] [RULE13]
        `PXC_CMP_NEG:    active_o = d < (lo + h);
        `PXC_CMP_POS:    active_o = d > (hi - h);
        `PXC_CMP_IN_WIN: active_o = (d > lo) && (d < hi);
        default:         active_o = (d < lo) || (d > hi);
      endcase
    end
  end
endmodule

// *** hw/pxc_regs.v ***
// Purpose: Setup and configuration registers behind a two-wire serial slave,
//          conversion sequencer and detection output
// Assumes: scl_i and sda_i synchronous to clock_i; SCL low and high phases
//          each last at least two clocks
// Notes:   Settings take effect at the start of the next conversion
// Functional notes
// [RULE1] Setup register at pointer 0x0b, 8 bits read/write, preset 0x0b.
// [RULE2] Setup holds range bits 7:6, reserved bit 5, hysteresis disable 4, settling 3:0.
// [RULE3] Range 00 is 2 pF step 4, 01 is 0.5 pF step 1, 10 is 1 pF step 2, 11 is 4 pF step 8.
// [RULE4] The host keeps setup bit 5 at zero when writing.
// [RULE5] Hysteresis disable set removes hysteresis in adaptive mode, clear applies it; here only compare modes 00 and 01 apply it.
// [RULE6] Fixed threshold mode never applies hysteresis.
// [RULE7] Settling field sets average settling from 2 to 65536 conversion cycles.
// [RULE8] Configuration register at pointer 0x0f, 8 bits read/write, preset 0x19.
// [RULE9] Config holds fixed bit 7, compare mode 6:5, enable 4, reserved 3, op mode 2:0.
// [RULE10] With fixed bit set, detection compares each result with the threshold register.
// [RULE11] With fixed bit clear, detection compares with the adaptive threshold from history.
// [RULE12] Compare mode bits pick the detect condition, differently for adaptive and fixed.
// [RULE13] Mode 00 below, 01 above, 10 inside band, 11 outside band; windows adaptive only.
// [RULE14] Op mode 000 idle, 001 continuous while enabled, 010 one conversion then idle.
// [RULE15] The host keeps the enable bit at one and config bit 3 at zero.
// [RULE16] Register writes reach conversion logic from the next conversion, not mid-conversion.
`timescale 1ns/100ps
`include "pxc_map.vh"
module pxc_regs
(
  input  wire        clock_i,
  input  wire        arst_n_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire [11:0] conv_data_i,
  input  wire [11:0] avg_i,
  input  wire [7:0]  sens_i,
  input  wire [11:0] thr_i,
  output wire        conv_start_o,
  output wire        conv_busy_o,
  output wire        detect_o,
  output wire [1:0]  range_sel_o,
  output wire [3:0]  offset_step_o,
  output wire [4:0]  settle_shift_o
);
  localparam integer CONV_CYCLES_I = `PXC_CONV_CYCLES;
  localparam [12:0]  CONV_CYCLES   = CONV_CYCLES_I[12:0];
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ADDR  = 3'h1;
  localparam [2:0] S_ACKA  = 3'h2;
  localparam [2:0] S_PTR   = 3'h3;
  localparam [2:0] S_ACKW  = 3'h4;
  localparam [2:0] S_WDATA = 3'h5;
  localparam [2:0] S_RDATA = 3'h6;
  localparam [2:0] S_RACK  = 3'h7;
  localparam C_IDLE = 1'b0;
  localparam C_RUN  = 1'b1;
  // Auto-offset step per range code
  function [3:0] step_of;
    input [1:0] rng;
    begin
      case (rng)
        2'h0:    step_of = 4'h4;
        2'h1:    step_of = 4'h1;
        2'h2:    step_of = 4'h2;
        default: step_of = 4'h8;
      endcase
    end
  endfunction
  reg [7:0]  setup_q;
  reg [7:0]  config_q;
  reg        scl_q;
  reg        sda_q;
  reg [2:0]  st_q;
  reg [3:0]  bit_q;
  reg [7:0]  sh_q;
  reg [7:0]  ptr_q;
  reg        rw_q;
  reg        nack_q;
  reg        sda_oe_q;
  reg        sda_out_q;
  reg        wr_q;
  reg [7:0]  wr_ptr_q;
  reg [7:0]  wr_data_q;
  reg        cst_q;
  reg [12:0] cnt_q;
  reg        start_q;
  reg        busy_q;
  reg        det_q;
  reg [1:0]  a_range_q;
  reg [3:0]  a_step_q;
  reg [4:0]  a_shift_q;
  reg        a_hyst_dis_q;
  reg        a_const_q;
  reg [1:0]  a_cmp_q;
  reg        single_q;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire       cmp_active;
  wire [2:0] op_mode;
  reg  [7:0] rd_byte;
  assign scl_rise   = scl_i && !scl_q;
  assign scl_fall   = !scl_i && scl_q;
  assign start_cond = scl_i && scl_q && sda_q && !sda_i;
  assign stop_cond  = scl_i && scl_q && !sda_q && sda_i;
  assign op_mode    = config_q[`PXC_CF_OP_MSB:`PXC_CF_OP_LSB];
  // Read mux; unmapped pointers read zero
  always @*
  begin
    case (ptr_q)
      `PXC_ADDR_SETUP:  rd_byte = setup_q;
      `PXC_ADDR_CONFIG: rd_byte = config_q;
      default:          rd_byte = 8'h00;
    endcase
  end
  // Serial slave
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      st_q      <= S_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
      sda_out_q <= 1'b0;
      wr_q      <= 1'b0;
      wr_ptr_q  <= 8'h00;
      wr_data_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_q  <= 1'b0;
      if (start_cond)
      begin
        st_q     <= S_ADDR;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_cond)
      begin
        st_q     <= S_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if ((st_q == S_ADDR || st_q == S_PTR || st_q == S_WDATA) && bit_q != 4'h8)
        begin
          sh_q  <= {sh_q[6:0], sda_i};
          bit_q <= bit_q + 4'h1;
        end
        if (st_q == S_RACK)
          nack_q <= sda_i;
      end
      else if (scl_fall)
      begin
        case (st_q)
          S_ADDR:
            if (bit_q == 4'h8)
            begin
              if (sh_q[7:1] == `PXC_DEV_ADDR)
              begin
                sda_oe_q <= 1'b1;
                rw_q     <= sh_q[0];
                st_q     <= S_ACKA;
              end
              else
                st_q <= S_IDLE;
            end
          S_ACKA:
          begin
            bit_q <= 4'h0;
            if (rw_q)
            begin
              sh_q     <= rd_byte;
              sda_oe_q <= !rd_byte[7];
              ptr_q    <= ptr_q + 8'h01;
              st_q     <= S_RDATA;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              st_q     <= S_PTR;
            end
          end
          S_PTR:
            if (bit_q == 4'h8)
            begin
              ptr_q    <= sh_q;
              sda_oe_q <= 1'b1;
              st_q     <= S_ACKW;
            end
          S_WDATA:
            if (bit_q == 4'h8)
            begin
              wr_q      <= 1'b1;
              wr_ptr_q  <= ptr_q;
              wr_data_q <= sh_q;
              ptr_q     <= ptr_q + 8'h01;
              sda_oe_q  <= 1'b1;
              st_q      <= S_ACKW;
            end
          S_ACKW:
          begin
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
            st_q     <= S_WDATA;
          end
          S_RDATA:
            if (bit_q == 4'h7)
            begin
              sda_oe_q <= 1'b0;
              st_q     <= S_RACK;
            end
            else
            begin
              bit_q    <= bit_q + 4'h1;
              sh_q     <= {sh_q[6:0], 1'b0};
              sda_oe_q <= !sh_q[6];
            end
          S_RACK:
            if (nack_q)
              st_q <= S_IDLE;
            else
            begin
              sh_q     <= rd_byte;
              sda_oe_q <= !rd_byte[7];
              ptr_q    <= ptr_q + 8'h01;
              bit_q    <= 4'h0;
              st_q     <= S_RDATA;
            end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end
  // Register file
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      setup_q  <= `PXC_RST_SETUP; // [RULE1]
      config_q <= `PXC_RST_CONFIG; // [RULE8]
    end
    else
    begin
      if (wr_q && wr_ptr_q == `PXC_ADDR_SETUP)
        setup_q <= wr_data_q; // [RULE1] [RULE2]
      if (wr_q && wr_ptr_q == `PXC_ADDR_CONFIG)
        config_q <= wr_data_q; // [RULE8] [RULE9]
      else if (busy_q && cnt_q == CONV_CYCLES - 13'h1 && single_q)
        config_q[`PXC_CF_OP_MSB:`PXC_CF_OP_LSB] <= `PXC_OP_IDLE; // [RULE14]
    end
  end

  pxc_cmp u_cmp
  (
    .data_i      (conv_data_i),
    .avg_i       (avg_i),
    .sens_i      (sens_i),
    .thr_i       (thr_i),
    .const_thr_i (a_const_q),
    .cmp_mode_i  (a_cmp_q),
    .hyst_dis_i  (a_hyst_dis_q),
    .prev_i      (det_q),
    .active_o    (cmp_active)
  );

  // Conversion sequencer; settings latched at each conversion start
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cst_q        <= C_IDLE;
      cnt_q        <= 13'h0000;
      start_q      <= 1'b0;
      busy_q       <= 1'b0;
      det_q        <= 1'b0;
      single_q     <= 1'b0;
      a_range_q    <= 2'h0;
      a_step_q     <= 4'h4;
      a_shift_q    <= 5'h0c;
      a_hyst_dis_q <= 1'b0;
      a_const_q    <= 1'b0;
      a_cmp_q      <= 2'h0;
    end
    else
    begin
      start_q <= 1'b0;
      case (cst_q)
        C_IDLE:
          if (config_q[`PXC_CF_CONV_EN] &&
              (op_mode == `PXC_OP_CONT || op_mode == `PXC_OP_SINGLE)) // [RULE14]
          begin
            cst_q        <= C_RUN;
            cnt_q        <= 13'h0000;
            start_q      <= 1'b1;
            busy_q       <= 1'b1;
            single_q     <= op_mode == `PXC_OP_SINGLE;
            a_range_q    <= setup_q[`PXC_SU_RANGE_HI:`PXC_SU_RANGE_LO]; // [RULE16]
            a_step_q     <= step_of(setup_q[`PXC_SU_RANGE_HI:`PXC_SU_RANGE_LO]); // [RULE3]
            a_shift_q    <= {1'b0, setup_q[`PXC_SU_SETTLE_MSB:`PXC_SU_SETTLE_LSB]}
                            + 5'h01; // [RULE7]
            a_hyst_dis_q <= setup_q[`PXC_SU_HYST_DIS]; // [RULE5]
            a_const_q    <= config_q[`PXC_CF_CONST_THR]; // [RULE16]
            a_cmp_q      <= config_q[`PXC_CF_CMP_MSB:`PXC_CF_CMP_LSB];
          end
        C_RUN:
          if (cnt_q == CONV_CYCLES - 13'h1)
          begin
            cst_q  <= C_IDLE;
            busy_q <= 1'b0;
            det_q  <= cmp_active; // [RULE10] [RULE11] [RULE12]
          end
          else
            cnt_q <= cnt_q + 13'h0001;
        default:
          cst_q <= C_IDLE;
      endcase
    end
  end

  assign sda_o          = sda_out_q;
  assign sda_oe_o       = sda_oe_q;
  assign conv_start_o   = start_q;
  assign conv_busy_o    = busy_q;
  assign detect_o       = det_q;
  assign range_sel_o    = a_range_q;
  assign offset_step_o  = a_step_q;
  assign settle_shift_o = a_shift_q;
endmodule

// *** dv/pxc_regs_sva.sv ***
// Purpose: Port checks for the proximity setup block
// Assumes: One clock, async active-low reset
// Notes:   Bound to every pxc_regs instance
`timescale 1ns/100ps
`include "pxc_map.vh"
module pxc_regs_sva
(
  input wire        clock_i,
  input wire        arst_n_i,
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire [11:0] conv_data_i,
  input wire [11:0] avg_i,
  input wire [7:0]  sens_i,
  input wire [11:0] thr_i,
  input wire        conv_start_o,
  input wire        conv_busy_o,
  input wire        detect_o,
  input wire [1:0]  range_sel_o,
  input wire [3:0]  offset_step_o,
  input wire [4:0]  settle_shift_o
);
  reg [10:0] busy_cnt_q;
  // Busy cycles of the running conversion
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      busy_cnt_q <= 11'h0;
    else if (conv_start_o)
      busy_cnt_q <= 11'h1;
    else if (conv_busy_o)
      busy_cnt_q <= busy_cnt_q + 11'h1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  property p_preset;
    $rose(arst_n_i) |=> conv_start_o && range_sel_o == 2'h0 && settle_shift_o == 5'h0c;
  endproperty
  a_preset: assert property (p_preset) else $error("presets not applied");
  property p_start;
    conv_start_o |-> conv_busy_o ##1 !conv_start_o;
  endproperty
  a_start: assert property (p_start) else $error("bad start pulse");
  property p_len;
    $fell(conv_busy_o) |-> busy_cnt_q == `PXC_CONV_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("bad conversion length");
  property p_detect;
    $changed(detect_o) |-> $fell(conv_busy_o);
  endproperty
  a_detect: assert property (p_detect) else $error("detect moved mid-conversion");
  property p_hold;
    conv_busy_o && !conv_start_o |-> $stable({range_sel_o, offset_step_o, settle_shift_o});
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved mid-conversion");
  property p_step;
    offset_step_o == (range_sel_o == 2'h0 ? 4'h4 :
                      range_sel_o == 2'h3 ? 4'h8 : {2'h0, range_sel_o});
  endproperty
  a_step: assert property (p_step) else $error("bad offset step");
  property p_settle;
    settle_shift_o >= 5'h01 && settle_shift_o <= 5'h10;
  endproperty
  a_settle: assert property (p_settle) else $error("bad settle shift");
  property p_sda;
    $changed(sda_oe_o) |-> !scl_i && sda_o == 1'b0;
  endproperty
  a_sda: assert property (p_sda) else $error("sda moved with scl high");
endmodule

bind pxc_regs pxc_regs_sva u_sva (.*);

// *** dv/pxc_host.sv ***
// Purpose: Serial host model driving the setup block
// Assumes: Open-drain SDA with pull-up resolved outside
// Notes:   Each SCL phase of a bit lasts 4 clocks
`timescale 1ns/100ps
`include "pxc_map.vh"
module pxc_host
(
  input  wire clock_i,
  input  wire sda_i,
  output reg  scl_o = 1'b1,
  output reg  sda_low_o = 1'b0
);
  task automatic gap;
    repeat (4) @(negedge clock_i);
  endtask
  task automatic bit_io(input b, output r);
  begin
    sda_low_o = ~b;
    gap;
    scl_o = 1'b1;
    gap;
    r = sda_i;
    scl_o = 1'b0;
  end
  endtask
  task automatic start;
  begin
    sda_low_o = 1'b0;
    gap;
    scl_o = 1'b1;
    gap;
    sda_low_o = 1'b1;
    gap;
    scl_o = 1'b0;
  end
  endtask
  task automatic stop;
  begin
    sda_low_o = 1'b1;
    gap;
    scl_o = 1'b1;
    gap;
    sda_low_o = 1'b0;
    gap;
  end
  endtask
  // Byte then released ninth bit
  task automatic xfer(input [7:0] d, output [7:0] q, output a);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
  end
  endtask
  task automatic wr(input [7:0] p, input [7:0] d, output nak);
    reg [7:0] q;
    reg [2:0] a;
  begin
    start;
    xfer({`PXC_DEV_ADDR, 1'b0}, q, a[0]);
    xfer(p, q, a[1]);
    xfer(d, q, a[2]);
    stop;
    nak = |a;
  end
  endtask
  task automatic rd(input [7:0] p, output [7:0] q, output nak);
    reg [2:0] a;
    reg       x;
  begin
    start;
    xfer({`PXC_DEV_ADDR, 1'b0}, q, a[0]);
    xfer(p, q, a[1]);
    start;
    xfer({`PXC_DEV_ADDR, 1'b1}, q, a[2]);
    xfer(8'hff, q, x);
    stop;
    nak = |a;
  end
  endtask
endmodule

// *** dv/pxc_regs_tb_top.sv ***
// Purpose: Register, setting and detection tests
// Assumes: 200 MHz clock
// Notes:   avg 0x800, sens 0x10, thr 0x7f0
`timescale 1ns/100ps
module pxc_regs_tb_top;
  reg         clock;
  reg         arst_n;
  reg  [11:0] data;
  reg  [7:0]  q;
  reg  [3:0]  f;
  reg         nak;
  wire        scl;
  wire        sda_low;
  wire        sda_oe;
  wire        start;
  wire        busy;
  wire        detect;
  wire [1:0]  range;
  wire [3:0]  step;
  wire [4:0]  settle;
  wire        sda = ~(sda_low | sda_oe);
  integer     n_errors;
  integer     n_tests;
  integer     i;
  integer     k;

  pxc_host u_host (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  pxc_regs u_dut (.clock_i(clock), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .conv_data_i(data), .avg_i(12'h800), .sens_i(8'h10),
    .thr_i(12'h7f0), .conv_start_o(start), .conv_busy_o(busy), .detect_o(detect),
    .range_sel_o(range), .offset_step_o(step), .settle_shift_o(settle));

  task automatic chk(input [7:0] got, input [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task automatic wait_end;
  begin
    for (k = 0; busy !== 1'b1 && k < 2500; k = k + 1)
      @(negedge clock);
    chk({7'h0, busy}, 8'h01);
    for (k = 0; busy !== 1'b0 && k < 2500; k = k + 1)
      @(negedge clock);
    chk({7'h0, busy}, 8'h00);
  end
  endtask
  // Setup, config, data, expected detect
  task automatic det(input [28:0] v);
  begin
    u_host.wr(8'h0b, v[28:21], nak);
    u_host.wr(8'h0f, v[20:13], nak);
    data = v[12:1];
    wait_end;
    wait_end;
    chk({7'h0, detect}, {7'h0, v[0]});
  end
  endtask
  task finish_test;
  begin
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (80000) @(posedge clock);
    n_errors = n_errors + 1;
    finish_test;
  end
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    arst_n = 1'b0;
    data = 12'h700;
    repeat (16) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    u_host.rd(8'h0b, q, nak);
    chk(q, 8'h0b);
    u_host.rd(8'h0f, q, nak);
    chk(q, 8'h19);
    u_host.wr(8'h20, 8'haa, nak);
    chk({7'h0, nak}, 8'h00);
    u_host.rd(8'h20, q, nak);
    chk(q, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      f = i[3:0] * 4'h5;
      u_host.wr(8'h0b, {i[1:0], 1'b0, i[0], f}, nak);
      u_host.rd(8'h0b, q, nak);
      chk(q, {i[1:0], 1'b0, i[0], f});
      for (k = 0; start !== 1'b1 && k < 2500; k = k + 1)
        @(negedge clock);
      chk({7'h0, start}, 8'h01);
      q = {(i == 0) ? 4'h4 : (i == 3) ? 4'h8 : i[3:0], 2'h0, i[1:0]};
      chk({step, 2'h0, range}, q);
      chk({3'h0, settle}, {3'h0, f + 5'h1});
    end
    det({8'h0b, 8'h91, 12'h700, 1'b1});
    det({8'h0b, 8'h91, 12'h7f1, 1'b0});
    det({8'h0b, 8'hb1, 12'h700, 1'b0});
    det({8'h0b, 8'hb1, 12'h900, 1'b1});
    det({8'h0b, 8'hd1, 12'h800, 1'b0});
    det({8'h0b, 8'hf1, 12'h700, 1'b0});
    det({8'h1b, 8'h11, 12'h7e0, 1'b1});
    det({8'h1b, 8'h11, 12'h7f0, 1'b0});
    det({8'h1b, 8'h31, 12'h811, 1'b1});
    det({8'h1b, 8'h31, 12'h810, 1'b0});
    det({8'h1b, 8'h51, 12'h800, 1'b1});
    det({8'h1b, 8'h51, 12'h7f0, 1'b0});
    det({8'h1b, 8'h71, 12'h700, 1'b1});
    det({8'h1b, 8'h71, 12'h800, 1'b0});
    det({8'h0b, 8'h11, 12'h700, 1'b1});
    det({8'h0b, 8'h11, 12'h7f2, 1'b1});
    u_host.wr(8'h0f, 8'h12, nak);
    wait_end;
    wait_end;
    u_host.rd(8'h0f, q, nak);
    chk(q, 8'h10);
    k = 0;
    for (i = 0; i < 1500; i = i + 1)
    begin
      @(negedge clock);
      k = k + start;
    end
    chk(k[7:0], 8'h00);
    finish_test;
  end
endmodule
